/* logic/mcu_instruction_decoder.sv */
// instruction decoder with apb register access
`timescale 1ns/10ps

module mcu_instruction_decoder
  import decoder_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic [1:0]       phase,
  output logic             skip_active,
  output logic             table_busy
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] instr;
    logic [3:0]  ctrl;
    logic [1:0]  phase;
    logic [1:0]  cycles_left;
    logic        skip_pending;
    logic        skip_active;
    logic        table_busy;
    logic [7:0]  working_register;
    logic [7:0]  bank_select_register;
    logic [15:0] product;
    logic [15:0] pc;
    logic [7:0]  file_result;
    logic [6:0]  flags_touched;
    logic        pop_stack;
    logic        global_interrupt_disable;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } state_type;

  state_type cur_r;
  state_type cur_nxt;

  op_type     op;
  logic [1:0] cycles;
  logic [6:0] flags;
  logic       is_skip;
  logic       cond_true;
  logic [7:0] lit;
  logic [2:0] bsel;
  logic [8:0] diff;
  logic [4:0] ndiff;
  logic       reduced;
  logic       access;

  assign lit     = cur_r.instr[7:0];
  assign bsel    = cur_r.instr[10:8];
  assign reduced = cur_r.ctrl[ctrl_reduced_bit];
  assign access  = psel && penable && !cur_r.pready;

  // ----------------------------------------------------------------
  // opcode decode
  // ----------------------------------------------------------------
  always_comb begin
    op = op_reserved;
    casez (cur_r.instr)
      16'h0000:              op = op_nop;
      16'h0002:              op = op_return;
      16'h0003:              op = op_sleep;
      16'h0004:              op = op_watchdog_clear;
      16'h0005:              op = op_interrupt_return;
      16'b0000_110?_????????: op = op_xor_file;
      16'b0011_0011_????????: op = op_test_skip_zero;
      16'b0011_1???_????????: op = op_bit_toggle;
      16'b1000_1???_????????: op = op_bit_clear;
      16'b1000_0???_????????: op = op_bit_set;
      16'b1001_1???_????????: op = op_test_skip_clear;
      16'b1001_0???_????????: op = op_test_skip_set;
      16'b1010_00??_????????: op = op_latch_read;
      16'b1010_01??_????????: op = op_latch_write;
      16'b1010_10??_????????: op = op_table_read;
      16'b1010_11??_????????: op = op_table_write;
      16'b1011_0000_????????: op = op_load_literal;
      16'b1011_0001_????????: op = op_add_literal;
      16'b1011_0010_????????: op = op_subtract_from_literal;
      16'b1011_0011_????????: op = op_or_literal;
      16'b1011_0100_????????: op = op_xor_literal;
      16'b1011_0101_????????: op = op_and_literal;
      16'b1011_0110_????????: op = op_literal_return;
      16'b1011_0111_????????: op = op_long_call;
      16'b1011_1000_????????: op = op_bank_low_load;
      16'b1011_101?_????????: op = reduced ? op_reserved : op_bank_high_load;
      16'b1011_1100_????????: op = reduced ? op_reserved : op_multiply_literal;
      16'b111?_????_????????: op = op_call;
      16'b110?_????_????????: op = op_branch;
      default:               op = op_reserved;
    endcase
  end

  // ----------------------------------------------------------------
  // cycles, flags, skip condition
  // ----------------------------------------------------------------
  always_comb begin
    cycles    = cycles_one;
    flags     = flag_none;
    is_skip   = 1'b0;
    cond_true = 1'b0;
    case (op)
      op_xor_file, op_and_literal, op_or_literal, op_xor_literal:
        flags = flag_z;
      op_add_literal, op_subtract_from_literal:
        flags = flag_arith;
      op_watchdog_clear, op_sleep:
        flags = flag_to_pd;
      op_test_skip_zero: begin
        is_skip   = 1'b1;
        cond_true = cur_r.ctrl[ctrl_cond_bit];
      end
      op_test_skip_clear: begin
        is_skip   = 1'b1;
        cond_true = ~cur_r.ctrl[ctrl_cond_bit];
      end
      op_test_skip_set: begin
        is_skip   = 1'b1;
        cond_true = cur_r.ctrl[ctrl_cond_bit];
      end
      op_call, op_branch, op_long_call, op_return, op_literal_return:
        cycles = cycles_two;
      op_interrupt_return: begin
        cycles = cycles_two;
        flags  = flag_global_interrupt_disable;
      end
      op_table_read:
        cycles = (lit == 8'h02) ? cycles_three : cycles_two;
      op_table_write:
        cycles = cycles_two;
      default: cycles = cycles_one;
    endcase
    if (is_skip && cond_true) begin
      cycles = cycles_two;
    end
  end

  // ----------------------------------------------------------------
  // datapath arithmetic
  // ----------------------------------------------------------------
  assign diff  = {1'b0, lit} - {1'b0, cur_r.working_register};
  assign ndiff = {1'b0, lit[3:0]} - {1'b0, cur_r.working_register[3:0]};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    cur_nxt           = cur_r;
    cur_nxt.pready    = 1'b0;
    cur_nxt.pslverr   = 1'b0;
    cur_nxt.pop_stack = 1'b0;
    // four phases per instruction cycle
    cur_nxt.phase = cur_r.phase + 2'h1;
    if (cur_r.phase == 2'h0 && cur_r.cycles_left == 2'h0) begin
      // decode phase: first cycle of a fresh instruction
      // a forced no-op lasts exactly one instruction cycle
      cur_nxt.cycles_left   = cur_r.skip_pending ? 2'h1 : cycles;
      cur_nxt.flags_touched = flags;
      cur_nxt.skip_active   = cur_r.skip_pending;
      cur_nxt.skip_pending  = 1'b0;
    end
    if (cur_r.phase == phase_count) begin
      if (cur_r.cycles_left <= 2'h1 && !cur_r.skip_active) begin
        // write phase of the last cycle: commit results
        cur_nxt.cycles_left = 2'h0;
        case (op)
          op_load_literal:  cur_nxt.working_register = lit;
          op_and_literal:   cur_nxt.working_register = cur_r.working_register & lit;
          op_or_literal:    cur_nxt.working_register = cur_r.working_register | lit;
          op_xor_literal:   cur_nxt.working_register = cur_r.working_register ^ lit;
          op_add_literal:   cur_nxt.working_register = cur_r.working_register + lit;
          op_subtract_from_literal: begin
            cur_nxt.working_register = diff[7:0];
            cur_nxt.file_result      = {4'h0, ~diff[8], ~ndiff[4], 2'h0};
          end
          op_literal_return: begin
            cur_nxt.working_register = lit;
            cur_nxt.pop_stack        = 1'b1;
          end
          op_return: cur_nxt.pop_stack = 1'b1;
          op_interrupt_return: begin
            cur_nxt.pop_stack                = 1'b1;
            cur_nxt.global_interrupt_disable = 1'b0;
          end
          op_bank_low_load:
            cur_nxt.bank_select_register[3:0] = lit[3:0];
          op_bank_high_load:
            cur_nxt.bank_select_register[7:4] = lit[7:4];
          op_multiply_literal:
            cur_nxt.product = lit * cur_r.working_register;
          op_long_call: cur_nxt.pc = {cur_r.pc[15:8], lit};
          op_call, op_branch: cur_nxt.pc = {3'h0, cur_r.instr[12:0]};
          op_bit_clear:
            cur_nxt.file_result = cur_r.file_result & ~(8'h01 << bsel);
          op_bit_set:
            cur_nxt.file_result = cur_r.file_result | (8'h01 << bsel);
          op_bit_toggle:
            cur_nxt.file_result = cur_r.file_result ^ (8'h01 << bsel);
          op_xor_file: begin
            cur_nxt.file_result = cur_r.file_result ^ cur_r.working_register;
            if (!cur_r.instr[8]) begin
              cur_nxt.working_register =
                cur_r.file_result ^ cur_r.working_register;
            end
          end
          default: cur_nxt.file_result = cur_r.file_result;
        endcase
        if (is_skip && cond_true) begin
          cur_nxt.skip_pending = 1'b1;
        end
        cur_nxt.skip_active = 1'b0;
      end else if (cur_r.cycles_left > 2'h1) begin
        // internal table write holds until an interrupt ends it
        if (op == op_table_write && cur_r.ctrl[ctrl_internal_bit]
            && !cur_r.ctrl[ctrl_irq_bit]) begin
          cur_nxt.table_busy = 1'b1;
        end else begin
          cur_nxt.table_busy  = 1'b0;
          cur_nxt.cycles_left = cur_r.cycles_left - 2'h1;
        end
      end else begin
        cur_nxt.cycles_left = 2'h0;
        cur_nxt.skip_active = 1'b0;
      end
    end
    // ----------------------------------------------------------------
    // apb slave: one wait state, answer in the second access cycle
    // ----------------------------------------------------------------
    if (access) begin
      cur_nxt.pready = 1'b1;
      cur_nxt.prdata = 32'h0000_0000;
      case (paddr)
        instr_off: begin
          if (pwrite) cur_nxt.instr = pwdata[15:0];
          cur_nxt.prdata = {16'h0000, cur_r.instr};
        end
        ctrl_off: begin
          if (pwrite) cur_nxt.ctrl = pwdata[3:0];
          cur_nxt.prdata = {28'h0000000, cur_r.ctrl};
        end
        decode_off: cur_nxt.prdata = {8'h00, 1'b0, flags, 6'h00, cycles,
                                      3'h0, op_type'(op) == op_reserved, 3'h0, is_skip};
        state_off:  cur_nxt.prdata = {cur_r.pc, 3'h0, cur_r.global_interrupt_disable,
                                      cur_r.pop_stack, cur_r.table_busy,
                                      cur_r.skip_active, cur_r.skip_pending,
                                      cur_r.flags_touched, 1'b0};
        datapath_off: cur_nxt.prdata = {cur_r.working_register,
                                        cur_r.bank_select_register, cur_r.product};
        default: cur_nxt.pslverr = 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_r                          <= '0;
      cur_r.ctrl                     <= ctrl_reset;
      cur_r.working_register         <= working_register_reset;
      cur_r.bank_select_register     <= bank_reset;
      cur_r.global_interrupt_disable <= 1'b1;
    end else if (clk_en) begin
      cur_r <= cur_nxt;
    end
  end

  assign pready      = cur_r.pready;
  assign prdata      = cur_r.prdata;
  assign pslverr     = cur_r.pslverr;
  assign phase       = cur_r.phase;
  assign skip_active = cur_r.skip_active;
  assign table_busy  = cur_r.table_busy;

endmodule : mcu_instruction_decoder

/* logic/decoder_pkg.sv */
// shared constants for the instruction decoder
package decoder_pkg;

  // ----------------------------------------------------------------
  // register offsets (apb byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] instr_off      = 8'h00;
  localparam logic [7:0] ctrl_off       = 8'h04;
  localparam logic [7:0] decode_off     = 8'h08;
  localparam logic [7:0] state_off      = 8'h0C;
  localparam logic [7:0] datapath_off   = 8'h10;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int         ctrl_reduced_bit  = 0;
  localparam int         ctrl_internal_bit = 1;
  localparam int         ctrl_irq_bit      = 2;
  localparam int         ctrl_cond_bit     = 3;
  localparam logic [3:0] ctrl_reset        = 4'h0;
  localparam logic [7:0] bank_reset        = 8'h00;
  localparam logic [7:0] working_register_reset        = 8'h00;

  // ----------------------------------------------------------------
  // phase and cycle counts
  // ----------------------------------------------------------------
  localparam logic [1:0] phase_count       = 2'h3;
  localparam logic [1:0] cycles_one        = 2'h1;
  localparam logic [1:0] cycles_two        = 2'h2;
  localparam logic [1:0] cycles_three      = 2'h3;

  // ----------------------------------------------------------------
  // status flag masks: {ov, z, dc, c, pd, to, global_interrupt_disable}
  // ----------------------------------------------------------------
  localparam logic [6:0] flag_none   = 7'h00;
  localparam logic [6:0] flag_z      = 7'h20;
  localparam logic [6:0] flag_arith  = 7'h78;
  localparam logic [6:0] flag_to_pd  = 7'h06;
  localparam logic [6:0] flag_global_interrupt_disable = 7'h01;

  typedef enum {
    op_nop, op_xor_file, op_table_write, op_table_read, op_latch_read,
    op_latch_write, op_test_skip_zero, op_bit_clear, op_bit_set,
    op_test_skip_clear, op_test_skip_set, op_bit_toggle, op_add_literal,
    op_and_literal, op_or_literal, op_xor_literal, op_call, op_branch,
    op_long_call, op_watchdog_clear, op_sleep, op_bank_low_load,
    op_bank_high_load, op_load_literal, op_multiply_literal,
    op_interrupt_return, op_literal_return, op_return,
    op_subtract_from_literal, op_reserved
  } op_type;

endpackage : decoder_pkg

/* bench/decoder_checker.sv */
// concurrent checks on the decoder ports
`timescale 1ns/10ps
module decoder_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [1:0]  phase,
  input wire logic        skip_active
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ------------------------------------------------------------
  // phase sequencing
  // ------------------------------------------------------------
  phase_step_a: assert property (clk_en |=> phase == $past(phase) + 2'h1)
    else $error("phase did not advance by one");
  phase_hold_a: assert property (!clk_en |=> $stable(phase))
    else $error("phase moved while frozen");
  skip_start_a: assert property ($rose(skip_active) |-> phase == 2'h1)
    else $error("forced no-op began off the decode phase");
  skip_length_a: assert property ($rose(skip_active) && clk_en |->
    skip_active [*3] ##1 !skip_active)
    else $error("forced no-op not one instruction cycle");

  // ------------------------------------------------------------
  // register bus answer
  // ------------------------------------------------------------
  ready_wait_a: assert property ($rose(penable) && psel && clk_en |=> pready)
    else $error("no answer one cycle after the access phase");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  ready_cause_a: assert property (pready |-> $past(psel) && $past(penable))
    else $error("ready without an access");
  error_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer malformed");
  rdata_hold_a: assert property (!pready |-> $stable(prdata))
    else $error("read data changed outside an answer");
endmodule : decoder_checker

bind mcu_instruction_decoder decoder_checker u_chk (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .phase(phase),
  .skip_active(skip_active)
);

/* bench/prog_mem.sv */
// program memory model handing instruction words to the bench
`timescale 1ns/10ps
module prog_mem (
  input  wire logic        pclk,
  input  wire logic        fetch,
  input  wire logic        slow,
  input  wire logic [4:0]  addr,
  output logic             word_valid,
  output logic [15:0]      word
);
  localparam logic [15:0] rom [25] = '{16'h0C05, 16'hB5FF, 16'hB300, 16'hB400, 16'hB801,
    16'hBA10, 16'hBC03, 16'h0005, 16'hB607, 16'hB200, 16'hB015, 16'hB700, 16'hE000,
    16'hC000, 16'h0004, 16'h0003, 16'h0002, 16'h8800, 16'h8000, 16'h3800, 16'hA000,
    16'hA400, 16'hAC00, 16'hA802, 16'hA805};
  logic        busy_r  = 1'b0;
  logic        valid_r = 1'b0;
  logic [2:0]  wait_r  = 3'h0;
  logic [15:0] word_r  = 16'hA5A5;
  assign word_valid = valid_r;
  assign word       = word_r;
  always_ff @(posedge pclk) begin
    valid_r <= 1'b0;
    if (!fetch) begin
      busy_r <= 1'b0;
      // idle bus toggles so a stale word never passes for data
      word_r <= ~word_r;
    end else if (!busy_r) begin
      busy_r <= 1'b1;
      wait_r <= slow ? 3'h4 : 3'h0;
    end else if (wait_r != 3'h0) begin
      wait_r <= wait_r - 3'h1;
    end else if (!valid_r) begin
      word_r  <= rom[addr];
      valid_r <= 1'b1;
    end
  end
endmodule : prog_mem

/* bench/tb.sv */
// self-checking bench for the instruction decoder
`timescale 1ns/10ps
module tb;
  import decoder_pkg::*;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic        skip_active, table_busy, e, ok, s, fetch_req, slow, word_valid;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0]  phase;
  logic [4:0]  rom_addr;
  logic [15:0] word, w;
  int          miscompares, check_count, cyc;
  // {affected flags, cycles} for each program memory entry
  localparam logic [8:0] xp [25] = '{9'h081, 9'h081, 9'h081, 9'h081, 9'h001, 9'h001,
    9'h001, 9'h006, 9'h002, 9'h1E1, 9'h001, 9'h002, 9'h002, 9'h002, 9'h019, 9'h019,
    9'h002, 9'h001, 9'h001, 9'h001, 9'h001, 9'h001, 9'h002, 9'h003, 9'h002};
  localparam logic [15:0] sk [3] = '{16'h9000, 16'h9800, 16'h3300};

  mcu_instruction_decoder DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .phase(phase),
    .skip_active(skip_active), .table_busy(table_busy));
  prog_mem u_mem (.pclk(pclk), .fetch(fetch_req), .slow(slow), .addr(rom_addr),
    .word_valid(word_valid), .word(word));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rq = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic fetch(input logic [4:0] a, input logic sl, output logic [15:0] fw);
    fetch_req <= 1'b1;
    rom_addr  <= a;
    slow      <= sl;
    @(posedge pclk);
    while (word_valid !== 1'b1) @(posedge pclk);
    fw = word;
    fetch_req <= 1'b0;
    @(posedge pclk);
  endtask : fetch

  // long enough for a three-cycle instruction plus phase alignment
  task automatic run(input logic [15:0] op);
    apb(1'b1, instr_off, {16'h0, op}, q, e);
    repeat (16) @(posedge pclk);
  endtask : run

  task automatic opc(input logic [15:0] op, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] x);
    run(op);
    apb(1'b0, a, 32'h0, q, e);
    check($sformatf("op %h reg %h", op, a), x, q & m);
  endtask : opc

  task automatic wait_flag(input logic sel, input logic v, output logic fo);
    int n = 0;
    while ((sel ? table_busy : skip_active) !== v && n < 20) begin
      @(posedge pclk);
      n++;
    end
    fo = n < 20;
  endtask : wait_flag

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 8000) begin
      miscompares++;
      $display("ERROR timeout expected %0d seen %0d", 8000, cyc);
      tally_and_finish();
    end
  end

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    presetn   = 1'b0;
    clk_en    = 1'b1;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    fetch_req = 1'b0;
    slow      = 1'b0;
    rom_addr  = 5'h00;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    opc(16'h0000, ctrl_off, 32'hFFFFFFFF, {28'h0, ctrl_reset});
    apb(1'b0, state_off, 32'h0, q, e);
    check("interrupt disable at reset", 32'h1000, q & 32'h1000);
    apb(1'b0, 8'h14, 32'h0, q, e);
    check("unmapped error", 32'h1, {31'h0, e});
    check("unmapped data", 32'h0, q);
    opc(16'hB015, datapath_off, 32'hFF000000, 32'h15000000);
    opc(16'hB30A, datapath_off, 32'hFF000000, 32'h1F000000);
    opc(16'hB50F, datapath_off, 32'hFF000000, 32'h0F000000);
    opc(16'hBC03, datapath_off, 32'h0000FFFF, 32'h0000002D);
    opc(16'hB8A5, datapath_off, 32'h00FF0000, 32'h00050000);
    opc(16'hBA3F, datapath_off, 32'h00FF0000, 32'h00350000);
    opc(16'hB677, datapath_off, 32'hFF000000, 32'h77000000);
    clk_en <= 1'b0;
    repeat (6) @(posedge pclk);
    clk_en <= 1'b1;
    for (int i = 0; i < 25; i++) begin
      fetch(5'(i), i[0], w);
      run(w);
      apb(1'b0, decode_off, 32'h0, q, e);
      check("decode", {9'h0, xp[i][8:2], 6'h0, xp[i][1:0], 8'h0}, q & 32'h007F0310);
    end
    for (int c = 0; c < 2; c++) begin
      apb(1'b1, ctrl_off, {28'h0, c[0], 3'h0}, q, e);
      for (int j = 0; j < 3; j++) begin
        run(sk[j]);
        s = (j == 1) ? ~c[0] : c[0];
        apb(1'b0, decode_off, 32'h0, q, e);
        check("skip decode", {22'h0, s, ~s, 7'h0, 1'b1}, q & 32'h00000311);
        wait_flag(1'b0, 1'b1, ok);
        check("forced no-op", {31'h0, s}, {31'h0, ok});
      end
    end
    apb(1'b1, ctrl_off, 32'h1, q, e);
    opc(16'hBC02, decode_off, 32'h10, 32'h10);
    opc(16'hBA02, decode_off, 32'h10, 32'h10);
    apb(1'b1, ctrl_off, 32'h2, q, e);
    run(16'hAC00);
    wait_flag(1'b1, 1'b1, ok);
    check("table write stall", 32'h1, {31'h0, ok});
    apb(1'b1, ctrl_off, 32'h6, q, e);
    wait_flag(1'b1, 1'b0, ok);
    check("table write end", 32'h1, {31'h0, ok});
    apb(1'b1, ctrl_off, 32'h0, q, e);
    opc(16'h0005, state_off, 32'h1000, 32'h0);
    tally_and_finish();
  end
endmodule : tb
